/* design/ddr_regs.svh */
// port addresses, field positions and reset values of the dual channel controller registers
`ifndef DDR_REGS_SVH
`define DDR_REGS_SVH

// per-channel memory address ports
`define DDR_CH0_ADDR_PORT 8'h00
`define DDR_CH1_ADDR_PORT 8'h02
`define DDR_CH2_ADDR_PORT 8'h04
`define DDR_CH3_ADDR_PORT 8'h06
`define DDR_CH4_ADDR_PORT 8'hc0
`define DDR_CH5_ADDR_PORT 8'hc4
`define DDR_CH6_ADDR_PORT 8'hc8
`define DDR_CH7_ADDR_PORT 8'hcc

// per-channel transfer count ports
`define DDR_CH0_COUNT_PORT 8'h01
`define DDR_CH1_COUNT_PORT 8'h03
`define DDR_CH2_COUNT_PORT 8'h05
`define DDR_CH3_COUNT_PORT 8'h07
`define DDR_CH4_COUNT_PORT 8'hc2
`define DDR_CH5_COUNT_PORT 8'hc6
`define DDR_CH6_COUNT_PORT 8'hca
`define DDR_CH7_COUNT_PORT 8'hce

// per-channel page ports
`define DDR_CH0_PAGE_PORT 8'h87
`define DDR_CH1_PAGE_PORT 8'h83
`define DDR_CH2_PAGE_PORT 8'h81
`define DDR_CH3_PAGE_PORT 8'h82
`define DDR_CH4_PAGE_PORT 8'h8f
`define DDR_CH5_PAGE_PORT 8'h8b
`define DDR_CH6_PAGE_PORT 8'h89
`define DDR_CH7_PAGE_PORT 8'h8a

// low channel controller ports
`define DDR_LO_STATUS_PORT   8'h08
`define DDR_LO_CFG_WR_PORT   8'h08
`define DDR_LO_REQ_PORT      8'h09
`define DDR_LO_CFG_RD_PORT   8'h0a
`define DDR_LO_MODE_PORT     8'h0b
`define DDR_LO_SCRATCH_PORT  8'h0d
`define DDR_LO_MASK_PORT     8'h0f

// high channel controller ports
`define DDR_HI_STATUS_PORT   8'hd0
`define DDR_HI_CFG_WR_PORT   8'hd0
`define DDR_HI_REQ_PORT      8'hd2
`define DDR_HI_CFG_RD_PORT   8'hd4
`define DDR_HI_MODE_PORT     8'hd6
`define DDR_HI_SCRATCH_PORT  8'hda
`define DDR_HI_MASK_PORT     8'hde

// field positions
`define DDR_MODE_SEL_LSB     6
`define DDR_MODE_DEC_BIT     5
`define DDR_MODE_AUTO_BIT    4
`define DDR_MODE_XFER_LSB    2
`define DDR_REQ_SET_BIT      2
`define DDR_CFG_DISABLE_BIT  2

// reset and fixed read values
`define DDR_CFG_RESET        8'h00
`define DDR_MASK_RESET       4'hf
`define DDR_SCRATCH_VALUE    8'h00
`define DDR_UNMAPPED_VALUE   8'hff

`endif

/* design/ddr_pkg.sv */
// types shared by the dual channel controller register front end
package ddr_pkg;
   typedef logic [2:0] ddr_chan_t;
   typedef enum logic [1:0] {
      DDR_MODE_DEMAND  = 2'h0,
      DDR_MODE_SINGLE  = 2'h1,
      DDR_MODE_BLOCK   = 2'h2,
      DDR_MODE_CASCADE = 2'h3
   } ddr_mode_e;
   typedef enum logic [1:0] {
      DDR_XFER_VERIFY   = 2'h0,
      DDR_XFER_MEM_WR   = 2'h1,
      DDR_XFER_MEM_RD   = 2'h2,
      DDR_XFER_RESERVED = 2'h3
   } ddr_xfer_e;
endpackage

/* design/ddr_dma_regs.sv */
// register front end of two cascaded four-channel transfer controllers, with read fifo
`timescale 1ns/1ps
`include "ddr_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// small synchronous fifo, registered storage
module ddr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             mclk_in,
   input  wire logic             resetn_in,
   // fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0]    wr_ptr_q, wr_ptr_d;
   logic [PW-1:0]    rd_ptr_q, rd_ptr_d;
   logic [PW:0]      fill_q,   fill_d;
   logic             push, pop;

   // handshakes straight from the fill level
   assign in_ready_out  = (fill_q != (PW+1)'(DEPTH));
   assign out_valid_out = (fill_q != '0);
   assign out_data_out  = mem_q[rd_ptr_q];
   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;

   // next pointers, level and storage
   always_comb begin
      mem_d    = mem_q;
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      fill_d   = fill_q;
      if (push) begin
         mem_d[wr_ptr_q] = in_data_in;
         wr_ptr_d = (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
         rd_ptr_d = (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
         fill_d = fill_q + 1'b1;
      end else if (pop && !push) begin
         fill_d = fill_q - 1'b1;
      end
   end

   // register fifo state
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fill_q   <= '0;
      end else begin
         mem_q    <= mem_d;
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         fill_q   <= fill_d;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// register file of both controllers and their page registers
module ddr_dma_regs #(
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        resetn_in,
   // host i/o port request
   input  wire logic        io_req_valid_in,
   input  wire logic        io_req_write_in,
   input  wire logic [7:0]  io_addr_in,
   input  wire logic [7:0]  io_wdata_in,
   output logic             io_req_ready_out,
   // host read answer
   output logic             io_rdata_valid_out,
   output logic [7:0]       io_rdata_out,
   input  wire logic        io_rdata_ready_in,
   // transfer engine events
   input  wire logic [7:0]  dreq_in,
   input  wire logic [7:0]  tc_in,
   // channel setup towards the transfer engine
   output logic [1:0]       ctrl_enable_out,
   output logic [7:0]       chan_request_out,
   output logic [15:0]      chan_mode_out,
   output logic [7:0]       chan_decrement_out,
   output logic [7:0]       chan_autoinit_out,
   output logic [15:0]      chan_xfer_out,
   output logic [63:0]      chan_addr_out,
   output logic [63:0]      chan_count_out,
   output logic [63:0]      chan_page_out
);
   // memory address ports in channel order, each address register on a port of its own
   localparam logic [7:0] ADDR_PORT [8] = '{
      `DDR_CH0_ADDR_PORT,
      `DDR_CH1_ADDR_PORT,
      `DDR_CH2_ADDR_PORT,
      `DDR_CH3_ADDR_PORT,
      `DDR_CH4_ADDR_PORT,
      `DDR_CH5_ADDR_PORT,
      `DDR_CH6_ADDR_PORT,
      `DDR_CH7_ADDR_PORT
   };
   // transfer count ports in channel order
   localparam logic [7:0] COUNT_PORT [8] = '{
      `DDR_CH0_COUNT_PORT,
      `DDR_CH1_COUNT_PORT,
      `DDR_CH2_COUNT_PORT,
      `DDR_CH3_COUNT_PORT,
      `DDR_CH4_COUNT_PORT,
      `DDR_CH5_COUNT_PORT,
      `DDR_CH6_COUNT_PORT,
      `DDR_CH7_COUNT_PORT
   };
   // page ports in channel order; the addresses are not monotonic
   localparam logic [7:0] PAGE_PORT [8] = '{
      `DDR_CH0_PAGE_PORT,
      `DDR_CH1_PAGE_PORT,
      `DDR_CH2_PAGE_PORT,
      `DDR_CH3_PAGE_PORT,
      `DDR_CH4_PAGE_PORT,
      `DDR_CH5_PAGE_PORT,
      `DDR_CH6_PAGE_PORT,
      `DDR_CH7_PAGE_PORT
   };
   // controller ports, low controller first
   localparam logic [7:0] STATUS_PORT [2] = '{
      `DDR_LO_STATUS_PORT,
      `DDR_HI_STATUS_PORT
   };
   localparam logic [7:0] CFG_WR_PORT [2] = '{
      `DDR_LO_CFG_WR_PORT,
      `DDR_HI_CFG_WR_PORT
   };
   localparam logic [7:0] CFG_RD_PORT [2] = '{
      `DDR_LO_CFG_RD_PORT,
      `DDR_HI_CFG_RD_PORT
   };
   localparam logic [7:0] REQ_PORT [2] = '{
      `DDR_LO_REQ_PORT,
      `DDR_HI_REQ_PORT
   };
   localparam logic [7:0] MODE_PORT [2] = '{
      `DDR_LO_MODE_PORT,
      `DDR_HI_MODE_PORT
   };
   localparam logic [7:0] SCRATCH_PORT [2] = '{
      `DDR_LO_SCRATCH_PORT,
      `DDR_HI_SCRATCH_PORT
   };
   localparam logic [7:0] MASK_PORT [2] = '{
      `DDR_LO_MASK_PORT,
      `DDR_HI_MASK_PORT
   };

   // register state: eight channels in two controllers of four
   logic [7:0] addr_q   [8];
   logic [7:0] addr_d   [8];
   logic [7:0] count_q  [8];
   logic [7:0] count_d  [8];
   logic [7:0] page_q   [8];
   logic [7:0] page_d   [8];
   logic [5:0] mode_q   [8];
   logic [5:0] mode_d   [8];
   logic [7:0] cfg_q    [2];
   logic [7:0] cfg_d    [2];
   logic [1:0] rb_ptr_q [2];
   logic [1:0] rb_ptr_d [2];
   logic [7:0] soft_req_q, soft_req_d;
   logic [7:0] mask_q,     mask_d;
   logic [7:0] tc_q,       tc_d;

   logic       fifo_in_ready;
   logic       wr_take;
   logic       rd_take;
   logic [7:0] rd_value;
   logic [7:0] pending;

   // requests: writes always taken, reads only with room for the answer
   assign wr_take          = io_req_valid_in & io_req_write_in;
   assign rd_take          = io_req_valid_in & ~io_req_write_in & fifo_in_ready;
   assign io_req_ready_out = io_req_write_in | fifo_in_ready;
   assign pending          = soft_req_q | dreq_in;

   // next register values from host writes, reads and engine events
   always_comb begin
      ddr_pkg::ddr_chan_t idx;
      idx        = '0;
      addr_d     = addr_q;
      count_d    = count_q;
      page_d     = page_q;
      mode_d     = mode_q;
      cfg_d      = cfg_q;
      rb_ptr_d   = rb_ptr_q;
      soft_req_d = soft_req_q;
      mask_d     = mask_q;
      tc_d       = tc_q;
      // a finished channel drops its software request
      soft_req_d = soft_req_d & ~tc_in;
      if (wr_take) begin
         for (int c = 0; c < 8; c++) begin
            if (io_addr_in == ADDR_PORT[c]) begin
               addr_d[c] = io_wdata_in;
            end
            if (io_addr_in == COUNT_PORT[c]) begin
               count_d[c] = io_wdata_in;
            end
            if (io_addr_in == PAGE_PORT[c]) begin
               page_d[c] = io_wdata_in;
            end
         end
         for (int k = 0; k < 2; k++) begin
            idx = {1'(k), io_wdata_in[1:0]};
            if (io_addr_in == CFG_WR_PORT[k]) begin
               cfg_d[k] = io_wdata_in;
            end
            if (io_addr_in == REQ_PORT[k]) begin
               soft_req_d[idx] = io_wdata_in[`DDR_REQ_SET_BIT];
            end
            if (io_addr_in == MODE_PORT[k]) begin
               mode_d[idx] = io_wdata_in[7:2];
               rb_ptr_d[k] = '0;
            end
            if (io_addr_in == MASK_PORT[k]) begin
               mask_d[4*k +: 4] = io_wdata_in[3:0];
            end
         end
      end
      // read side effects only once the answer has room in the fifo
      if (rd_take) begin
         for (int k = 0; k < 2; k++) begin
            if (io_addr_in == STATUS_PORT[k]) begin
               tc_d[4*k +: 4] = 4'h0;
            end
            if (io_addr_in == MODE_PORT[k]) begin
               rb_ptr_d[k] = rb_ptr_q[k] + 2'h1;
            end
         end
      end
      // a new terminal count beats a clearing status read
      tc_d = tc_d | tc_in;
   end

   // read value of the addressed port
   always_comb begin
      rd_value = `DDR_UNMAPPED_VALUE;
      for (int c = 0; c < 8; c++) begin
         if (io_addr_in == ADDR_PORT[c]) begin
            rd_value = addr_q[c];
         end
         if (io_addr_in == COUNT_PORT[c]) begin
            rd_value = count_q[c];
         end
         if (io_addr_in == PAGE_PORT[c]) begin
            rd_value = page_q[c];
         end
      end
      for (int k = 0; k < 2; k++) begin
         if (io_addr_in == STATUS_PORT[k]) begin
            rd_value = {pending[4*k +: 4], tc_q[4*k +: 4]};
         end
         if (io_addr_in == CFG_RD_PORT[k]) begin
            rd_value = cfg_q[k];
         end
         if (io_addr_in == REQ_PORT[k]) begin
            rd_value = {4'h0, soft_req_q[4*k +: 4]};
         end
         if (io_addr_in == MODE_PORT[k]) begin
            rd_value = {mode_q[{1'(k), rb_ptr_q[k]}], rb_ptr_q[k]};
         end
         if (io_addr_in == SCRATCH_PORT[k]) begin
            rd_value = `DDR_SCRATCH_VALUE;
         end
         if (io_addr_in == MASK_PORT[k]) begin
            rd_value = {4'h0, mask_q[4*k +: 4]};
         end
      end
   end

   // register all state
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int c = 0; c < 8; c++) begin
            addr_q[c]  <= 8'h00;
            count_q[c] <= 8'h00;
            page_q[c]  <= 8'h00;
            mode_q[c]  <= 6'h00;
         end
         for (int k = 0; k < 2; k++) begin
            cfg_q[k]    <= `DDR_CFG_RESET;
            rb_ptr_q[k] <= 2'h0;
         end
         soft_req_q <= 8'h00;
         mask_q     <= {2{`DDR_MASK_RESET}};
         tc_q       <= 8'h00;
      end else begin
         addr_q     <= addr_d;
         count_q    <= count_d;
         page_q     <= page_d;
         mode_q     <= mode_d;
         cfg_q      <= cfg_d;
         rb_ptr_q   <= rb_ptr_d;
         soft_req_q <= soft_req_d;
         mask_q     <= mask_d;
         tc_q       <= tc_d;
      end
   end

   // read answers queue here until the host takes them
   ddr_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) ddr_fifo_inst (
      .mclk_in       (mclk_in),
      .resetn_in     (resetn_in),
      .in_valid_in   (rd_take),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (rd_value),
      .out_valid_out (io_rdata_valid_out),
      .out_ready_in  (io_rdata_ready_in),
      .out_data_out  (io_rdata_out)
   );

   // channel setup decoded from the registers
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         ctrl_enable_out[k] = ~cfg_q[k][`DDR_CFG_DISABLE_BIT];
      end
      for (int c = 0; c < 8; c++) begin
         chan_request_out[c]      = pending[c] & ~mask_q[c] & ctrl_enable_out[c/4];
         chan_mode_out[2*c +: 2]  = mode_q[c][`DDR_MODE_SEL_LSB-2 +: 2];
         chan_decrement_out[c]    = mode_q[c][`DDR_MODE_DEC_BIT-2];
         chan_autoinit_out[c]     = mode_q[c][`DDR_MODE_AUTO_BIT-2];
         chan_xfer_out[2*c +: 2]  = mode_q[c][`DDR_MODE_XFER_LSB-2 +: 2];
         chan_addr_out[8*c +: 8]  = addr_q[c];
         chan_count_out[8*c +: 8] = count_q[c];
         chan_page_out[8*c +: 8]  = page_q[c];
      end
   end
endmodule

/* dv/ddr_dma_regs_props.sv */
// port assertions of the dual controller register front end
`timescale 1ns/1ps
module ddr_dma_regs_props #(
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input wire logic        mclk_in,
   input wire logic        resetn_in,
   // host port
   input wire logic        io_req_valid_in,
   input wire logic        io_req_write_in,
   input wire logic [7:0]  io_addr_in,
   input wire logic [7:0]  io_wdata_in,
   input wire logic        io_req_ready_out,
   input wire logic        io_rdata_valid_out,
   input wire logic [7:0]  io_rdata_out,
   input wire logic        io_rdata_ready_in,
   // channel setup
   input wire logic [1:0]  ctrl_enable_out,
   input wire logic [7:0]  chan_request_out,
   input wire logic [15:0] chan_mode_out,
   input wire logic [7:0]  chan_decrement_out,
   input wire logic [7:0]  chan_autoinit_out,
   input wire logic [15:0] chan_xfer_out,
   input wire logic [63:0] chan_addr_out,
   input wire logic [63:0] chan_count_out,
   input wire logic [63:0] chan_page_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   // write strobe, qualified by the port at each use
   logic wr_go;
   assign wr_go = io_req_valid_in && io_req_write_in;
   property p_rd_answer;
      io_req_valid_in && !io_req_write_in && !io_rdata_valid_out |=> io_rdata_valid_out;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_wr_ready;
      io_req_valid_in && io_req_write_in |-> io_req_ready_out;
   endproperty
   a_wr_ready: assert property (p_wr_ready) else $error("write refused");
   property p_hold;
      io_rdata_valid_out && !io_rdata_ready_in |=> io_rdata_valid_out && $stable(io_rdata_out);
   endproperty
   a_hold: assert property (p_hold) else $error("answer dropped");
   property p_cfg_lo;
      wr_go && io_addr_in == 8'h08 |=> ctrl_enable_out[0] == !$past(io_wdata_in[2]);
   endproperty
   a_cfg_lo: assert property (p_cfg_lo) else $error("low enable wrong");
   property p_cfg_hi;
      wr_go && io_addr_in == 8'hd0 |=> ctrl_enable_out[1] == !$past(io_wdata_in[2]);
   endproperty
   a_cfg_hi: assert property (p_cfg_hi) else $error("high enable wrong");
   property p_gate;
      (chan_request_out & ~{{4{ctrl_enable_out[1]}}, {4{ctrl_enable_out[0]}}}) == 8'h00;
   endproperty
   a_gate: assert property (p_gate) else $error("request while disabled");
   property p_mode_lo;
      wr_go && io_addr_in == 8'h0b |=>
         chan_mode_out[2*$past(io_wdata_in[1:0]) +: 2] == $past(io_wdata_in[7:6])
         && chan_decrement_out[$past(io_wdata_in[1:0])] == $past(io_wdata_in[5]);
   endproperty
   a_mode_lo: assert property (p_mode_lo) else $error("low mode wrong");
   property p_mode_hi;
      wr_go && io_addr_in == 8'hd6 |=>
         chan_xfer_out[8+2*$past(io_wdata_in[1:0]) +: 2] == $past(io_wdata_in[3:2])
         && chan_autoinit_out[4+$past(io_wdata_in[1:0])] == $past(io_wdata_in[4]);
   endproperty
   a_mode_hi: assert property (p_mode_hi) else $error("high transfer wrong");
   property p_addr;
      wr_go && io_addr_in == 8'hc0 |=> chan_addr_out[39:32] == $past(io_wdata_in);
   endproperty
   a_addr: assert property (p_addr) else $error("channel 4 address wrong");
   property p_count;
      wr_go && io_addr_in == 8'h01 |=> chan_count_out[7:0] == $past(io_wdata_in);
   endproperty
   a_count: assert property (p_count) else $error("channel 0 count wrong");
   property p_page;
      wr_go && io_addr_in == 8'h8a |=> chan_page_out[63:56] == $past(io_wdata_in);
   endproperty
   a_page: assert property (p_page) else $error("channel 7 page wrong");
   // main scenarios
   c_full: cover property (!io_req_ready_out);
   c_take: cover property (io_rdata_valid_out && io_rdata_ready_in);
   c_cfg: cover property (wr_go && io_addr_in == 8'h08);
endmodule
bind ddr_dma_regs ddr_dma_regs_props #(.FIFO_DEPTH(FIFO_DEPTH)) ddr_dma_regs_props_inst (
   .mclk_in(mclk_in), .resetn_in(resetn_in), .io_req_valid_in(io_req_valid_in),
   .io_req_write_in(io_req_write_in), .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in),
   .io_req_ready_out(io_req_ready_out), .io_rdata_valid_out(io_rdata_valid_out),
   .io_rdata_out(io_rdata_out), .io_rdata_ready_in(io_rdata_ready_in),
   .ctrl_enable_out(ctrl_enable_out), .chan_request_out(chan_request_out),
   .chan_mode_out(chan_mode_out), .chan_decrement_out(chan_decrement_out),
   .chan_autoinit_out(chan_autoinit_out), .chan_xfer_out(chan_xfer_out),
   .chan_addr_out(chan_addr_out), .chan_count_out(chan_count_out),
   .chan_page_out(chan_page_out));

/* dv/ddr_host_model.sv */
// host processor model issuing i/o port reads and writes
`timescale 1ns/1ps
module ddr_host_model (
   // clock
   input  wire logic  mclk_in,
   // request side
   output logic       valid_out,
   output logic       write_out,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   input  wire logic  ready_in,
   // answer side
   output logic       rdata_ready_out
);
   logic stall = 1'b0;
   // quiet bus at time zero
   initial begin
      valid_out = 1'b0;
      write_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
      rdata_ready_out = 1'b1;
   end
   // answers taken each cycle unless stalled
   always @(posedge mclk_in) rdata_ready_out <= ~stall;
   // one access to one port, held until taken
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      valid_out <= 1'b1;
      write_out <= wr;
      addr_out <= a;
      wdata_out <= d;
      do @(posedge mclk_in); while (!wr && ready_in !== 1'b1);
   endtask
   // valid drops; address and data lines show the inverse of their last value
   task automatic idle();
      valid_out <= 1'b0;
      addr_out <= ~addr_out;
      wdata_out <= ~wdata_out;
   endtask
endmodule

/* dv/ddr_dma_regs_tb_top.sv */
// self-checking bench of the dual controller register front end
`timescale 1ns/1ps
module ddr_dma_regs_tb_top;
   logic        mclk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        vld, wrt, rdy, rvld, rrdy;
   logic [7:0]  adr, wd, rdat, d;
   logic [7:0]  dreq_in = 8'h00;
   logic [7:0]  tc_in = 8'h00;
   logic [1:0]  en;
   logic [7:0]  creq, cdec;
   logic [15:0] cmode, cxfer;
   logic [7:0]  exp_q[$], port_q[$];
   logic [31:0] seed = 32'hf024;
   int          mismatches = 0;
   int          checks_done = 0;
   logic [7:0]  pt[24] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'hc0, 8'hc4, 8'hc8, 8'hcc,
                          8'h01, 8'h03, 8'h05, 8'h07, 8'hc2, 8'hc6, 8'hca, 8'hce,
                          8'h87, 8'h83, 8'h81, 8'h82, 8'h8f, 8'h8b, 8'h89, 8'h8a};
   always #2.5 mclk_in = ~mclk_in;
   ddr_dma_regs #(.FIFO_DEPTH(4)) ddr_dma_regs_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .io_req_valid_in(vld), .io_req_write_in(wrt), .io_addr_in(adr), .io_wdata_in(wd),
      .io_req_ready_out(rdy), .io_rdata_valid_out(rvld), .io_rdata_out(rdat),
      .io_rdata_ready_in(rrdy), .dreq_in(dreq_in), .tc_in(tc_in), .ctrl_enable_out(en),
      .chan_request_out(creq), .chan_mode_out(cmode), .chan_decrement_out(cdec),
      .chan_autoinit_out(), .chan_xfer_out(cxfer), .chan_addr_out(), .chan_count_out(),
      .chan_page_out());
   ddr_host_model ddr_host_model_inst (.mclk_in(mclk_in), .valid_out(vld), .write_out(wrt),
      .addr_out(adr), .wdata_out(wd), .ready_in(rdy), .rdata_ready_out(rrdy));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // mode byte for channel c: mode, direction, auto-init, transfer style, channel
   function automatic logic [7:0] md(int c);
      return {c[1:0], c[0], c[1], (c[1:0] == 2'h3) ? 2'h0 : c[1:0], c[1:0]};
   endfunction
   task automatic check(input logic [7:0] name, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD port %h expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      ddr_host_model_inst.xfer(1'b1, a, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      port_q.push_back(a);
      ddr_host_model_inst.xfer(1'b0, a, 8'h00);
   endtask
   // release the bus and let the last edge land
   task automatic rest();
      ddr_host_model_inst.idle();
      #1;
   endtask
   task automatic pulse(input logic [7:0] v);
      rest();
      @(posedge mclk_in);
      tc_in <= v;
      @(posedge mclk_in);
      tc_in <= 8'h00;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // answers compared against the oldest note
   always @(posedge mclk_in)
      if (resetn_in && rvld === 1'b1 && rrdy === 1'b1)
         check(port_q.pop_front(), rdat, exp_q.pop_front());
   // watchdog
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      check(8'h08, en, 2'b11);
      check(8'h0f, creq, 8'h00);
      rd(8'h0f, 8'h0f);
      rd(8'hde, 8'h0f);
      rd(8'h0a, 8'h00);
      rd(8'h0d, 8'h00);
      rd(8'hda, 8'h00);
      rd(8'h10, 8'hff);
      $display("test reset done");
      for (int i = 0; i < 24; i++) begin
         d = rnd();
         wr(pt[i], d);
         rd(pt[i], d);
      end
      $display("test channels done");
      for (int c = 0; c < 8; c++) wr(c < 4 ? 8'h0b : 8'hd6, md(c));
      rest();
      for (int c = 0; c < 8; c++) begin
         check(8'h0b, cmode[2*c+:2], c[1:0]);
         check(8'h0b, cdec[c], c[0]);
         check(8'h0b, cxfer[2*c+:2], (c[1:0] == 2'h3) ? 2'h0 : c[1:0]);
      end
      @(posedge mclk_in);
      for (int c = 0; c < 8; c++) rd(c < 4 ? 8'h0b : 8'hd6, md(c));
      $display("test mode done");
      wr(8'h0f, 8'h05);
      wr(8'hde, 8'h00);
      wr(8'h08, 8'h04);
      wr(8'hd0, 8'h04);
      rd(8'h0a, 8'h04);
      rd(8'hd4, 8'h04);
      wr(8'hd0, 8'h00);
      dreq_in <= 8'hff;
      rest();
      check(8'h08, en, 2'b10);
      check(8'h0f, creq, 8'hf0);
      @(posedge mclk_in);
      wr(8'h08, 8'h00);
      rest();
      check(8'h0f, creq, 8'hfa);
      $display("test config done");
      pulse(8'h21);
      rd(8'h08, 8'hf1);
      rd(8'h08, 8'hf0);
      rd(8'hd0, 8'hf2);
      rd(8'hd0, 8'hf0);
      dreq_in <= 8'h00;
      wr(8'h09, 8'h06);
      wr(8'hd2, 8'h07);
      rd(8'h09, 8'h04);
      rd(8'hd2, 8'h08);
      rd(8'h08, 8'h40);
      pulse(8'h04);
      rd(8'h09, 8'h00);
      rd(8'h08, 8'h04);
      $display("test status done");
      rest();
      @(posedge mclk_in);
      ddr_host_model_inst.stall <= 1'b1;
      @(posedge mclk_in);
      for (int i = 0; i < 4; i++) rd(8'h0d, 8'h00);
      rest();
      check(8'h0d, rdy, 1'b0);
      ddr_host_model_inst.stall <= 1'b0;
      repeat (10) @(posedge mclk_in);
      check(8'h00, exp_q.size(), 0);
      $display("test fifo done");
      // second reset in mid-run restores the mask and drops soft requests
      resetn_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      check(8'h08, en, 2'b11);
      rd(8'h0f, 8'h0f);
      rd(8'hd2, 8'h00);
      rest();
      repeat (4) @(posedge mclk_in);
      check(8'h00, exp_q.size(), 0);
      $display("test reset again done");
      print_verdict();
   end
endmodule
